/* rtl/timer0_counter_prescaler.sv */
// Timer/counter with edge select and a prescaler shared with the watchdog
//
// The strobed register port was chosen for this implementation.

// Notes on behaviour
// - Clock source select clear runs timer mode on the instruction cycle.
// - Timer mode without prescaler adds one to the count every cycle.
// - A count write holds off counting for the next two cycles.
// - Clock source select set counts transitions of the external pin.
// - Edge select clear counts rising edges, set counts falling edges.
// - One prescaler serves either the timer or the watchdog, not both.
// - Prescaler assign clear gives it to the timer, set to the watchdog.
// - Software can neither read nor write the prescaler count.
// - Timer prescale ratios run from 1:2 to 1:256 in powers of two.
// - The count is an 8-bit read/write register at address 01h.
// - Count is cleared to 00h at power-on, kept through soft resets.
module timer0_counter_prescaler (
  input wire logic mclk,                        // instruction-cycle clock
  input wire logic reset_n,                     // power-on reset, async
  input wire logic master_clear_pin_n,          // master clear pin
  input wire logic watchdog_reset,              // watchdog reset pulse
  input wire logic external_count_pin,          // external count pin
  input wire logic watchdog_tick,               // watchdog base tick
  input wire timer0_pkg::bus_req_t bus_req,     // register request
  output logic [7:0] rdata,                     // read data, next cycle
  output logic watchdog_prescaled_tick          // watchdog tick out
);

  timer0_pkg::control_t ctrl_reg;
  logic [7:0] timer_count_reg;
  logic [7:0] timer_count_next;
  logic [1:0] hold_reg;
  logic pin_level;
  logic pin_prev_reg;
  logic master_clear_pin_level_n;
  logic soft_reset;
  logic rise_hit;
  logic fall_hit;
  logic edge_hit;
  logic base_tick;
  logic presc_in;
  logic presc_out;
  logic presc_clear;
  logic [3:0] presc_log2;
  logic timer_tick;
  logic count_write;
  logic ctrl_write;
  logic count_inc;
  logic assign_prev_reg;

  assign count_write = bus_req.wr && (bus_req.addr == timer0_pkg::COUNT_ADDR);
  assign ctrl_write = bus_req.wr && (bus_req.addr == timer0_pkg::CTRL_ADDR);

  pin_sync #(.RESET_LEVEL(1'b0)) u_count_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in(external_count_pin),
    .sync_out(pin_level)
  );

  // Master clear is a pin too, so it is synchronised
  pin_sync #(.RESET_LEVEL(1'b1)) u_master_clear_pin_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in(master_clear_pin_n),
    .sync_out(master_clear_pin_level_n)
  );

  assign soft_reset = !master_clear_pin_level_n || watchdog_reset;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_level;
    end
  end

  assign rise_hit = pin_level && !pin_prev_reg;
  assign fall_hit = !pin_level && pin_prev_reg;
  assign edge_hit = ctrl_reg.count_edge_select ? fall_hit : rise_hit;

  assign base_tick = ctrl_reg.clock_source_select ? edge_hit : 1'b1;

  // Control register; soft resets restore it like power-on
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= timer0_pkg::CTRL_RESET;
    end else if (soft_reset) begin
      ctrl_reg <= timer0_pkg::CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      assign_prev_reg <= 1'b1;
    end else begin
      assign_prev_reg <= ctrl_reg.prescaler_assign;
    end
  end

  // single prescaler, steered by assign bit
  assign presc_in = ctrl_reg.prescaler_assign ? watchdog_tick : base_tick;

  // timer ratio is one step above the rate field
  assign presc_log2 = ctrl_reg.prescaler_assign
    ? {1'b0, ctrl_reg.prescale_rate}
    : {1'b0, ctrl_reg.prescale_rate} + timer0_pkg::TIMER_LOG2_OFFSET;

  // Reassignment clears the count at the end of its first cycle, so in that cycle
  // presc_out can still fire from the old count; a timer-side count write also restarts it
  assign presc_clear = soft_reset
    || (assign_prev_reg != ctrl_reg.prescaler_assign)
    || (count_write && !ctrl_reg.prescaler_assign);

  // prescaler count has no bus path
  prescaler_unit u_prescaler (
    .mclk(mclk),
    .reset_n(reset_n),
    .clear(presc_clear),
    .tick_in(presc_in),
    .ratio_log2(presc_log2),
    .tick_out(presc_out)
  );

  assign watchdog_prescaled_tick = ctrl_reg.prescaler_assign && presc_out;

  assign timer_tick = ctrl_reg.prescaler_assign ? base_tick : presc_out;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= timer0_pkg::HOLD_IDLE;
    end else if (count_write && !soft_reset) begin
      hold_reg <= timer0_pkg::WRITE_HOLD_CYCLES;
    end else if (hold_reg != timer0_pkg::HOLD_IDLE) begin
      hold_reg <= hold_reg - timer0_pkg::HOLD_STEP;
    end
  end

  assign count_inc = timer_tick && (hold_reg == timer0_pkg::HOLD_IDLE)
    && !count_write && !soft_reset;
  assign timer_count_next = timer_count_reg + timer0_pkg::COUNT_STEP;

  // count register, untouched by soft resets
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_count_reg <= timer0_pkg::COUNT_POR;
    end else if (count_write && !soft_reset) begin
      timer_count_reg <= bus_req.wdata;
    end else if (count_inc) begin
      timer_count_reg <= timer_count_next;
    end
  end

  // Control is write-only; every other address reads zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= timer0_pkg::READ_ZERO;
    end else if (bus_req.rd && bus_req.addr == timer0_pkg::COUNT_ADDR) begin
      rdata <= timer_count_reg;
    end else begin
      rdata <= timer0_pkg::READ_ZERO;
    end
  end

  // Helper: prescaled-tick spacing in timer mode
  logic [8:0] gap_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= '0;
    end else if (presc_clear || presc_out) begin
      gap_reg <= '0;
    end else if (!gap_reg[8]) begin
      gap_reg <= gap_reg + 9'h001;
    end
  end

  // A rate change keeps the running count, so only a gap that starts at
  // a tick under unchanged settings is a full period
  logic gap_valid_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_valid_reg <= 1'b0;
    end else if (presc_clear || ctrl_write) begin
      gap_valid_reg <= 1'b0;
    end else if (presc_out) begin
      gap_valid_reg <= 1'b1;
    end
  end

  timer_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!ctrl_reg.clock_source_select && ctrl_reg.prescaler_assign
     && !count_write && !soft_reset && hold_reg == 2'h0)
    |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("timer mode did not step by one");

  // write loads then holds two cycles
  write_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (count_write && !soft_reset) ##1 !count_write ##1 !count_write
    |-> timer_count_reg == $past(bus_req.wdata, 2))
    else $error("count moved during write hold");

  // counter mode steps on an edge only
  counter_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl_reg.clock_source_select && ctrl_reg.prescaler_assign
     && !edge_hit && !count_write) |=> $stable(timer_count_reg))
    else $error("counter stepped without an edge");

  counter_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl_reg.clock_source_select && ctrl_reg.prescaler_assign
     && edge_hit && !count_write && !soft_reset && hold_reg == 2'h0)
    |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("counter missed a selected edge");

  // edge hit matches the selected polarity
  edge_pick_a: assert property (@(posedge mclk) disable iff (!reset_n)
    edge_hit |-> (pin_level == !ctrl_reg.count_edge_select)
      && (pin_level != $past(pin_level)))
    else $error("edge hit on wrong polarity");

  // watchdog gets nothing while timer owns it
  share_excl_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ctrl_reg.prescaler_assign |-> !watchdog_prescaled_tick)
    else $error("watchdog tick while prescaler owned by timer");

  // ratio 1:2 never ticks twice in a row
  ratio_two_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (presc_out && !ctrl_reg.prescaler_assign
     && ctrl_reg.prescale_rate == 3'h0 && !ctrl_write)
    |=> !presc_out)
    else $error("1:2 prescale ticked back to back");

  ratio_max_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (presc_out && gap_valid_reg && !ctrl_reg.prescaler_assign
     && !ctrl_reg.clock_source_select && ctrl_reg.prescale_rate == 3'h7)
    |-> gap_reg == 9'h0FF)
    else $error("1:256 period not 256 cycles");

  read_map_a: assert property (@(posedge mclk) disable iff (!reset_n)
    bus_req.rd |=> rdata == (($past(bus_req.addr) == 8'h01)
      ? $past(timer_count_reg) : 8'h00))
    else $error("read data wrong for address");

  soft_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    soft_reset |=> timer_count_reg == $past(timer_count_reg))
    else $error("soft reset changed the count");

  // read data is zero outside the cycle after a read
  rdata_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !bus_req.rd |=> rdata == 8'h00)
    else $error("read data not zero after a non-read cycle");

  // a count write lands on the next edge
  count_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (count_write && !soft_reset)
    |=> timer_count_reg == $past(bus_req.wdata))
    else $error("count write did not land");

  // no step while the hold runs
  hold_still_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (hold_reg != 2'h0 && !count_write) |=> $stable(timer_count_reg))
    else $error("count stepped inside the write hold");

  // soft resets put control back to its reset value
  ctrl_restore_a: assert property (@(posedge mclk) disable iff (!reset_n)
    soft_reset |=> ctrl_reg == timer0_pkg::CTRL_RESET)
    else $error("control not restored by soft reset");

  // watchdog output only follows a watchdog tick
  wdog_src_a: assert property (@(posedge mclk) disable iff (!reset_n)
    watchdog_prescaled_tick |-> watchdog_tick)
    else $error("watchdog tick without a base tick");

  // a timer-side count write restarts the period
  presc_fresh_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (count_write && !ctrl_reg.prescaler_assign && !soft_reset)
    |=> !presc_out)
    else $error("prescaler ticked right after a count write");

  // pin reaches the edge logic two edges late
  sync_lag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pin_level == $past(external_count_pin, 2))
    else $error("pin synchroniser latency wrong");

  timer_run_c: cover property (@(posedge mclk) disable iff (!reset_n)
    !ctrl_reg.clock_source_select && count_inc);
  edge_count_c: cover property (@(posedge mclk) disable iff (!reset_n)
    ctrl_reg.clock_source_select && edge_hit && count_inc);
  presc_tick_c: cover property (@(posedge mclk) disable iff (!reset_n)
    !ctrl_reg.prescaler_assign && presc_out && count_inc);
  wdt_tick_c: cover property (@(posedge mclk) disable iff (!reset_n)
    watchdog_prescaled_tick);
  soft_reset_c: cover property (@(posedge mclk) disable iff (!reset_n)
    soft_reset ##1 !soft_reset);

endmodule

/* pkg/timer0_pkg.sv */
// Shared constants and types for the timer/counter with prescaler
package timer0_pkg;

  // Register map
  localparam logic [7:0] COUNT_ADDR = 8'h01;
  localparam logic [7:0] CTRL_ADDR = 8'h10;

  // Control register layout and reset value
  localparam int CTRL_SRC_BIT = 5;
  localparam int CTRL_EDGE_BIT = 4;
  localparam int CTRL_ASSIGN_BIT = 3;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_RATE_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h3F;

  // Values that do not come from a reset source
  localparam logic [7:0] COUNT_POR = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  // Cycles of suppressed counting after a count write
  localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
  localparam logic [1:0] HOLD_IDLE = 2'h0;
  localparam logic [1:0] HOLD_STEP = 2'h1;

  // Prescaler geometry: ratio 2^log2, log2 in 0..8
  localparam int PRESC_W = 8;
  localparam logic [3:0] TIMER_LOG2_OFFSET = 4'h1;

  typedef struct packed {
    logic [1:0] unused;
    logic clock_source_select;
    logic count_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_rate;
  } control_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

/* rtl/pin_sync.sv */
// Two-stage synchroniser for one asynchronous input
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic mclk,      // instruction-cycle clock
  input wire logic reset_n,   // asynchronous power-on reset
  input wire logic async_in,  // level from a pin
  output logic sync_out       // level safe to use on mclk
);

  logic meta_reg;

  // First stage is read only by the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* rtl/prescaler_unit.sv */
// Shared 8-bit prescaler with power-of-two terminal tick
module prescaler_unit (
  input wire logic mclk,             // instruction-cycle clock
  input wire logic reset_n,          // asynchronous power-on reset
  input wire logic clear,            // restart the division period
  input wire logic tick_in,          // one source event
  input wire logic [3:0] ratio_log2, // division is 2^ratio_log2
  output logic tick_out              // end of a division period
);

  logic [timer0_pkg::PRESC_W-1:0] count_reg;
  logic [timer0_pkg::PRESC_W-1:0] count_next;
  logic [timer0_pkg::PRESC_W-1:0] mask;

  // Low ratio_log2 bits take part in the terminal match
  genvar i;
  generate
    for (i = 0; i < timer0_pkg::PRESC_W; i++) begin : g_mask
      assign mask[i] = (4'(i) < ratio_log2);
    end
  endgenerate

  assign count_next = count_reg + {{(timer0_pkg::PRESC_W-1){1'b0}}, 1'b1};
  assign tick_out = tick_in && ((count_reg & mask) == mask);

  // Count is internal only; nothing reads it from outside
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (clear) begin
      count_reg <= '0;
    end else if (tick_in) begin
      count_reg <= count_next;
    end
  end

endmodule

/* testbench/pulse_source.sv */
// Model of the source that drives the external count pin
module pulse_source (
  output logic pin = 1'h0  // level on the external count pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Levels last several clock periods and change off the clock grid, so
  // the synchroniser sees every level and the phase keeps drifting
  task automatic toggle(input int n);
    repeat (n) begin
      #37.3;
      pin = ~pin;
    end
    #37.3;
  endtask
endmodule

/* testbench/test_timer0_counter_prescaler.sv */
// Self-checking bench for the timer/counter with prescaler
module test_timer0_counter_prescaler;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk;
  logic reset_n;
  logic master_clear_pin_n;
  logic watchdog_reset;
  logic external_count_pin;
  logic watchdog_tick;
  timer0_pkg::bus_req_t bus_req;
  logic [7:0] rdata;
  logic watchdog_prescaled_tick;
  int num_errors;
  int checks;
  int ticks;
  logic [7:0] v0;
  logic [7:0] v1;

  timer0_counter_prescaler u_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .master_clear_pin_n(master_clear_pin_n),
    .watchdog_reset(watchdog_reset),
    .external_count_pin(external_count_pin),
    .watchdog_tick(watchdog_tick),
    .bus_req(bus_req),
    .rdata(rdata),
    .watchdog_prescaled_tick(watchdog_prescaled_tick)
  );

  pulse_source u_src (
    .pin(external_count_pin)
  );

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each bus task starts just after a rising edge and ends on one
  task automatic op(input logic [7:0] a, input logic [7:0] d,
                    input logic w, input logic r);
    bus_req <= '{a, d, w, r};
    @(posedge mclk);
  endtask

  task automatic idle(input int n);
    bus_req <= '{8'h00, 8'h00, 1'h0, 1'h0};
    repeat (n) @(posedge mclk);
  endtask

  // A write leaves its strobe up: always follow it with another bus task
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(a, d, 1'h1, 1'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    op(a, 8'h00, 1'h0, 1'h1);
    bus_req <= '{8'h00, 8'h00, 1'h0, 1'h0};
    #1;
    v = rdata;
    @(posedge mclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
                     input string what);
    logic [7:0] v;
    rd(a, v);
    check(what, exp, v);
  endtask

  task automatic wdog(output int t);
    t = 0;
    for (int i = 0; i < 32; i++) begin
      watchdog_tick <= i[0];
      #1;
      if (watchdog_prescaled_tick === 1'h1) t++;
      @(posedge mclk);
    end
    watchdog_tick <= 1'h0;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    $display("MISMATCH run length expected end seen hang");
    results();
  end

  initial begin
    reset_n = 1'h0;
    master_clear_pin_n = 1'h1;
    watchdog_reset = 1'h0;
    watchdog_tick = 1'h0;
    bus_req = '{8'h00, 8'h00, 1'h0, 1'h0};
    num_errors = 0;
    checks = 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    idle(3);
    rdc(timer0_pkg::COUNT_ADDR, 8'h00, "count at reset"); // reset
    wr(8'h02, 8'h55);
    rdc(timer0_pkg::COUNT_ADDR, 8'h00, "unmapped write"); // map
    rdc(timer0_pkg::CTRL_ADDR, 8'h00, "control read"); // hidden
    rdc(8'h02, 8'h00, "unmapped read"); // hidden
    wr(timer0_pkg::CTRL_ADDR, 8'h08); // timer mode
    wr(timer0_pkg::COUNT_ADDR, 8'hFF);
    rdc(timer0_pkg::COUNT_ADDR, 8'hFF, "hold 1"); // hold
    rdc(timer0_pkg::COUNT_ADDR, 8'hFF, "hold 2"); // hold
    rdc(timer0_pkg::COUNT_ADDR, 8'h01, "wrap"); // wrap
    rd(timer0_pkg::COUNT_ADDR, v0);
    rd(timer0_pkg::COUNT_ADDR, v1);
    check("free run", 8'h02, v1 - v0); // each cycle
    // Reads a whole number of periods apart, so the phase does not matter
    for (int n = 0; n < 8; n++) begin
      wr(timer0_pkg::CTRL_ADDR, {5'h00, n[2:0]}); // to timer
      wr(timer0_pkg::COUNT_ADDR, 8'h10); // restart
      idle(4);
      rd(timer0_pkg::COUNT_ADDR, v0);
      idle((2 << n) * 2 - 2);
      rd(timer0_pkg::COUNT_ADDR, v1);
      check("prescaled", 8'h02, v1 - v0); // ratio
    end
    wr(timer0_pkg::CTRL_ADDR, 8'h2A);
    idle(2);
    wdog(ticks);
    check("wdog ticks", 8'h04, ticks[7:0]); // to watchdog
    wr(timer0_pkg::CTRL_ADDR, 8'h22);
    idle(2);
    wdog(ticks);
    check("wdog idle", 8'h00, ticks[7:0]); // one user
    wr(timer0_pkg::CTRL_ADDR, 8'h28);
    wr(timer0_pkg::COUNT_ADDR, 8'h40);
    idle(4);
    u_src.toggle(5);
    @(posedge mclk);
    idle(4);
    rdc(timer0_pkg::COUNT_ADDR, 8'h43, "rising");
    wr(timer0_pkg::CTRL_ADDR, 8'h38);
    wr(timer0_pkg::COUNT_ADDR, 8'h40);
    idle(4);
    u_src.toggle(3);
    @(posedge mclk);
    idle(4);
    rdc(timer0_pkg::COUNT_ADDR, 8'h42, "falling"); // edges
    wr(timer0_pkg::CTRL_ADDR, 8'h28);
    wr(timer0_pkg::COUNT_ADDR, 8'hA5);
    idle(2);
    watchdog_reset <= 1'h1;
    @(posedge mclk);
    watchdog_reset <= 1'h0;
    idle(3);
    rdc(timer0_pkg::COUNT_ADDR, 8'hA5, "wdog reset"); // kept
    master_clear_pin_n <= 1'h0;
    idle(4);
    master_clear_pin_n <= 1'h1;
    idle(4);
    rdc(timer0_pkg::COUNT_ADDR, 8'hA5, "clear pin"); // kept
    // Control is back to falling edges, so a rising edge must not count
    u_src.toggle(1);
    @(posedge mclk);
    idle(4);
    rdc(timer0_pkg::COUNT_ADDR, 8'hA5, "ctrl restored"); // reset
    u_src.toggle(1);
    @(posedge mclk);
    idle(4);
    rdc(timer0_pkg::COUNT_ADDR, 8'hA6, "fall count"); // counting
    results();
  end
endmodule
